// ==== design/lfm_consts.vh ====
// Purpose: Constants for the LCD frame and mode configuration block
// Assumes: Wishbone byte address is four times the register index
// Notes:   Timing figures in Hz; cycle counts derived in the module
`ifndef LFM_CONSTS_VH
`define LFM_CONSTS_VH

// Register indices, byte address = index * 4
`define LFM_IDX_MODE      14'h2400
`define LFM_IDX_RAIL      14'h2401
`define LFM_IDX_CONTRAST  14'h240d
`define LFM_IDX_STATUS    14'h2410

// Field positions
`define LFM_DIV_LSB       0
`define LFM_DIV_MSB       1
`define LFM_MUX_LSB       4
`define LFM_MUX_MSB       6
`define LFM_RAIL_LSB      6
`define LFM_RAIL_MSB      7
`define LFM_DAC_LSB       0
`define LFM_DAC_MSB       4

// Reset values
`define LFM_DIV_RST       2'h0
`define LFM_MUX_RST       3'h0
`define LFM_RAIL_RST      2'h0
`define LFM_DAC_RST       5'h00

// Divider codes
`define LFM_DIV_512       2'h0
`define LFM_DIV_256       2'h1
`define LFM_DIV_128       2'h2
`define LFM_DIV_64        2'h3

// Multiplex codes
`define LFM_MUX_4_THIRD   3'h0
`define LFM_MUX_3_THIRD   3'h1
`define LFM_MUX_2_HALF    3'h2
`define LFM_MUX_3_HALF    3'h3
`define LFM_MUX_STATIC    3'h4
`define LFM_MUX_5_THIRD   3'h5
`define LFM_MUX_6_THIRD   3'h6
`define LFM_MUX_BAD       3'h7

// Drive rail codes
`define LFM_RAIL_DIRECT   2'h0
`define LFM_RAIL_DAC      2'h1
`define LFM_RAIL_BOOST    2'h2
`define LFM_RAIL_EXT      2'h3

// Timing
`define LFM_REF_HZ        32768
`define LFM_CLK_HZ        250000000

`endif

// ==== design/lfm_top.v ====
// Purpose: Frame clock, multiplex/bias and drive rail configuration
// Assumes: Classic Wishbone slave, 32-bit data, 250 MHz clk_i
// Notes:   Analog contrast transfer lives outside; only the code leaves here
`timescale 1ns/1ps
`include "lfm_consts.vh"

// Function
// - Frame clock is 32768 Hz divided by 512, 256, 128 or 64 per code.
// - Codes 000..011 give 4/3 states third bias, 2/3 states half bias.
// - Rail 11 external, 10 boost plus contrast DAC, 01 contrast DAC only.
// - Rail 00 keeps boost and contrast DAC off; rail from supply directly.
// - Five states turns one shared pin into common; six turns a second.
module lfm_top #(
    parameter REF_HZ = `LFM_REF_HZ,
    parameter CLK_HZ = `LFM_CLK_HZ
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [15:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // Panel timing
    output wire        frame_tick_o,
    output wire [5:0]  common_active_o,
    output wire [2:0]  slot_o,
    output wire        bias_third_o,
    output wire        static_drive_o,
    output wire        mode_unsupported_o,
    output wire        shared_pin_fifth_common_o,
    output wire        shared_pin_sixth_common_o,
    // Drive rail
    output wire        boost_circuit_enable_o,
    output wire        contrast_dac_enable_o,
    output wire        external_rail_o,
    output wire [4:0]  contrast_level_o
);

    // Accumulator width covers CLK_HZ up to 2^28
    localparam [27:0] ACC_INC = REF_HZ[27:0];
    localparam [27:0] ACC_MOD = CLK_HZ[27:0];

    reg [1:0]  div_sel_ff;
    reg [2:0]  mux_sel_ff;
    reg [1:0]  rail_sel_ff;
    reg [4:0]  contrast_ff;
    reg [31:0] dat_ff;
    reg        ack_ff;
    reg [27:0] acc_ff;
    reg        ref_en_ff;
    reg [8:0]  fdiv_ff;
    reg        tick_ff;
    reg [2:0]  slot_ff;
    reg [5:0]  com_ff;
    reg        third_ff;
    reg        static_ff;
    reg        bad_ff;
    reg        pin5_ff;
    reg        pin6_ff;
    reg        boost_ff;
    reg        dac_ff;
    reg        ext_ff;

    wire        req;
    wire        wr;
    wire [13:0] idx;
    reg  [31:0] nxt_dat;
    reg  [2:0]  nxt_states;
    reg         nxt_third;
    reg         fdiv_hit;
    wire [28:0] acc_sum;

    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    // Write lands on the edge where the master sees ack
    assign wr  = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[15:2];

    // Register writes; narrow fields sit in byte lane 0
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_sel_ff  <= `LFM_DIV_RST;
            mux_sel_ff  <= `LFM_MUX_RST;
            rail_sel_ff <= `LFM_RAIL_RST;
            contrast_ff <= `LFM_DAC_RST;
        end else if (wr) begin
            case (idx)
                `LFM_IDX_MODE: begin
                    div_sel_ff <= wb_dat_i[`LFM_DIV_MSB:`LFM_DIV_LSB];
                    mux_sel_ff <= wb_dat_i[`LFM_MUX_MSB:`LFM_MUX_LSB];
                end
                `LFM_IDX_RAIL: begin
                    rail_sel_ff <= wb_dat_i[`LFM_RAIL_MSB:`LFM_RAIL_LSB];
                end
                `LFM_IDX_CONTRAST: begin
                    contrast_ff <= wb_dat_i[`LFM_DAC_MSB:`LFM_DAC_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped reads return zero
    always @* begin
        nxt_dat = 32'h0000_0000;
        case (idx)
            `LFM_IDX_MODE: begin
                nxt_dat[`LFM_DIV_MSB:`LFM_DIV_LSB] = div_sel_ff;
                nxt_dat[`LFM_MUX_MSB:`LFM_MUX_LSB] = mux_sel_ff;
            end
            `LFM_IDX_RAIL: begin
                nxt_dat[`LFM_RAIL_MSB:`LFM_RAIL_LSB] = rail_sel_ff;
            end
            `LFM_IDX_CONTRAST: begin
                nxt_dat[`LFM_DAC_MSB:`LFM_DAC_LSB] = contrast_ff;
            end
            `LFM_IDX_STATUS: begin
                nxt_dat[2:0] = slot_ff;
                nxt_dat[3]   = bad_ff;
                nxt_dat[4]   = third_ff;
                nxt_dat[5]   = static_ff;
            end
            default: begin
                nxt_dat = 32'h0000_0000;
            end
        endcase
    end

    // One-cycle ack, every address answered
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (req) begin
                dat_ff <= nxt_dat;
            end
        end
    end

    // Fractional accumulator: 32768 Hz is no integer fraction of clk_i
    assign acc_sum = {1'b0, acc_ff} + {1'b0, ACC_INC};

    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff    <= 28'h0000000;
            ref_en_ff <= 1'b0;
        end else if (acc_sum >= {1'b0, ACC_MOD}) begin
            acc_ff    <= acc_sum[27:0] - ACC_MOD;
            ref_en_ff <= 1'b1;
        end else begin
            acc_ff    <= acc_sum[27:0];
            ref_en_ff <= 1'b0;
        end
    end

    // Power-of-two divider on the reference enable
    always @* begin
        case (div_sel_ff)
            `LFM_DIV_512: fdiv_hit = (fdiv_ff == 9'h1ff);
            `LFM_DIV_256: fdiv_hit = (fdiv_ff[7:0] == 8'hff);
            `LFM_DIV_128: fdiv_hit = (fdiv_ff[6:0] == 7'h7f);
            `LFM_DIV_64:  fdiv_hit = (fdiv_ff[5:0] == 6'h3f);
            default:      fdiv_hit = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fdiv_ff <= 9'h000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= ref_en_ff & fdiv_hit;
            if (ref_en_ff) begin
                fdiv_ff <= fdiv_ff + 9'h001;
            end
        end
    end

    // State count and bias per multiplex code
    always @* begin
        case (mux_sel_ff)
            `LFM_MUX_4_THIRD: begin
                nxt_states = 3'h4;
                nxt_third  = 1'b1;
            end
            `LFM_MUX_3_THIRD: begin
                nxt_states = 3'h3;
                nxt_third  = 1'b1;
            end
            `LFM_MUX_2_HALF: begin
                nxt_states = 3'h2;
                nxt_third  = 1'b0;
            end
            `LFM_MUX_3_HALF: begin
                nxt_states = 3'h3;
                nxt_third  = 1'b0;
            end
            `LFM_MUX_STATIC: begin
                nxt_states = 3'h1;
                nxt_third  = 1'b0;
            end
            `LFM_MUX_5_THIRD: begin
                nxt_states = 3'h5;
                nxt_third  = 1'b1;
            end
            `LFM_MUX_6_THIRD: begin
                nxt_states = 3'h6;
                nxt_third  = 1'b1;
            end
            default: begin
                nxt_states = 3'h0;
                nxt_third  = 1'b0;
            end
        endcase
    end

    // Slot sequencer; a mode change mid-frame restarts at slot 0 if out of range
    always @(posedge clk_i) begin
        if (rst_i) begin
            slot_ff <= 3'h0;
            com_ff  <= 6'h00;
        end else begin
            if (nxt_states == 3'h0) begin
                slot_ff <= 3'h0;
            end else if (slot_ff >= nxt_states) begin
                slot_ff <= 3'h0;
            end else if (tick_ff) begin
                if (slot_ff == nxt_states - 3'h1) begin
                    slot_ff <= 3'h0;
                end else begin
                    slot_ff <= slot_ff + 3'h1;
                end
            end
            if (nxt_states == 3'h0) begin
                com_ff <= 6'h00;
            end else begin
                com_ff <= 6'h01 << slot_ff;
            end
        end
    end

    // Mode decode and rail selection, registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            third_ff  <= 1'b0;
            static_ff <= 1'b0;
            bad_ff    <= 1'b0;
            pin5_ff   <= 1'b0;
            pin6_ff   <= 1'b0;
            boost_ff  <= 1'b0;
            dac_ff    <= 1'b0;
            ext_ff    <= 1'b0;
        end else begin
            third_ff  <= nxt_third;
            static_ff <= (mux_sel_ff == `LFM_MUX_STATIC);
            bad_ff    <= (mux_sel_ff == `LFM_MUX_BAD);
            pin5_ff   <= (mux_sel_ff == `LFM_MUX_5_THIRD) |
                         (mux_sel_ff == `LFM_MUX_6_THIRD);
            pin6_ff   <= (mux_sel_ff == `LFM_MUX_6_THIRD);
            boost_ff  <= (rail_sel_ff == `LFM_RAIL_BOOST);
            dac_ff    <= (rail_sel_ff == `LFM_RAIL_BOOST) |
                         (rail_sel_ff == `LFM_RAIL_DAC);
            ext_ff    <= (rail_sel_ff == `LFM_RAIL_EXT);
        end
    end

    assign wb_dat_o                  = dat_ff;
    assign wb_ack_o                  = ack_ff;
    assign frame_tick_o              = tick_ff;
    assign common_active_o           = com_ff;
    assign slot_o                    = slot_ff;
    assign bias_third_o              = third_ff;
    assign static_drive_o            = static_ff;
    assign mode_unsupported_o        = bad_ff;
    assign shared_pin_fifth_common_o = pin5_ff;
    assign shared_pin_sixth_common_o = pin6_ff;
    assign boost_circuit_enable_o    = boost_ff;
    assign contrast_dac_enable_o     = dac_ff;
    assign external_rail_o           = ext_ff;
    assign contrast_level_o          = contrast_ff;

endmodule // lfm_top

// ==== testbench/lfm_top_properties.sv ====
// Purpose: Port-level assertions for the frame/mode block
// Assumes: Sync active-high reset, one clock
// Notes:   Decoded flags checked as relations, not equations
`timescale 1ns/1ps
module lfm_chk (
    // Clock and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Panel and rail
    input wire logic        frame_tick_o,
    input wire logic [5:0]  common_active_o,
    input wire logic [2:0]  slot_o,
    input wire logic        bias_third_o,
    input wire logic        static_drive_o,
    input wire logic        mode_unsupported_o,
    input wire logic        shared_pin_fifth_common_o,
    input wire logic        shared_pin_sixth_common_o,
    input wire logic        boost_circuit_enable_o,
    input wire logic        contrast_dac_enable_o,
    input wire logic        external_rail_o,
    input wire logic [4:0]  contrast_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_boost_pair: assert property (boost_circuit_enable_o |-> contrast_dac_enable_o)
        else $error("boost without dac");
    a_ext_alone: assert property (external_rail_o |-> !contrast_dac_enable_o
        && !boost_circuit_enable_o) else $error("external rail with dac");
    a_sixth_fifth: assert property (shared_pin_sixth_common_o |->
        shared_pin_fifth_common_o && bias_third_o) else $error("sixth without fifth");
    a_static_alone: assert property (static_drive_o |-> !bias_third_o
        && !shared_pin_fifth_common_o) else $error("static flags");
    a_unsup_dark: assert property (mode_unsupported_o |-> common_active_o == 6'h00
        && !bias_third_o && !static_drive_o) else $error("code 111 drives");
    a_common_hot: assert property (!mode_unsupported_o && !$past(rst_i)
        && !$past(mode_unsupported_o) |-> $onehot(common_active_o)) else $error("commons");
    a_slot_tick: assert property ($changed(slot_o) |-> slot_o == 3'h0
        || frame_tick_o || $past(frame_tick_o)) else $error("slot moved off tick");
    a_tick_pulse: assert property (frame_tick_o |=> !frame_tick_o)
        else $error("tick too long");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_sixth: cover property (frame_tick_o && shared_pin_sixth_common_o);
    c_unsup: cover property (mode_unsupported_o);
    c_boost: cover property (boost_circuit_enable_o);
endmodule // lfm_chk

bind lfm_top lfm_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .frame_tick_o, .common_active_o, .slot_o,
    .bias_third_o, .static_drive_o, .mode_unsupported_o, .shared_pin_fifth_common_o,
    .shared_pin_sixth_common_o, .boost_circuit_enable_o, .contrast_dac_enable_o,
    .external_rail_o, .contrast_level_o);

// ==== testbench/lfm_glass.sv ====
// Purpose: Glass model measuring frame spacing and states per frame
// Assumes: Commons one-hot, slot 0 on bit 0
// Notes:   First frame after a mode change is mixed; read the second
`timescale 1ns/1ps
module lfm_glass (
    // Panel side
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        tick_i,
    input wire logic [5:0]  common_i,
    // Observations
    output wire logic [15:0] gap_o,
    output wire logic [3:0]  states_o,
    output wire logic [15:0] frames_o
);
    logic [15:0] run_ff, gap_ff, frm_ff;
    logic [3:0]  cnt_ff, st_ff;
    assign gap_o    = gap_ff;
    assign states_o = st_ff;
    assign frames_o = frm_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            {run_ff, gap_ff, frm_ff, cnt_ff, st_ff} <= '0;
        end else begin
            run_ff <= tick_i ? 16'h0001 : run_ff + 16'h0001;
            if (tick_i) begin
                gap_ff <= run_ff;
                cnt_ff <= (common_i == 6'h01) ? 4'h0 : cnt_ff + 4'h1;
                if (common_i == 6'h01) begin
                    st_ff  <= cnt_ff + 4'h1;
                    frm_ff <= frm_ff + 16'h0001;
                end
            end
        end
    end
endmodule // lfm_glass

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the frame/mode block
// Assumes: REF_HZ 16, CLK_HZ 64: one reference enable per 4 clocks
// Notes:   Random contrast from xorshift seeded 11
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [15:0] adr = 0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 0, q, r, seed = 11;
    wire  [31:0] rdat;
    wire         ack, tick, bias, stat, unsup, fifth, sixth, boost, dac, ext;
    wire  [5:0]  com;
    wire  [2:0]  slot;
    wire  [4:0]  lvl;
    wire  [15:0] gap, frames;
    wire  [3:0]  states;
    int          fail_count = 0, num_checks = 0;
    logic [15:0] regs [3] = '{16'h9000, 16'h9004, 16'h9034};
    lfm_top #(.REF_HZ(16), .CLK_HZ(64)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .frame_tick_o(tick), .common_active_o(com),
        .slot_o(slot), .bias_third_o(bias), .static_drive_o(stat), .mode_unsupported_o(unsup),
        .shared_pin_fifth_common_o(fifth), .shared_pin_sixth_common_o(sixth),
        .boost_circuit_enable_o(boost), .contrast_dac_enable_o(dac), .external_rail_o(ext),
        .contrast_level_o(lvl));
    lfm_glass u_glass (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .common_i(com),
        .gap_o(gap), .states_o(states), .frames_o(frames));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] exp_dec(input logic [2:0] m, input logic [1:0] v);
        return {m inside {0, 1, 5, 6}, m == 4, m == 7, m inside {5, 6}, m == 6,
                v == 2, v inside {1, 2}, v == 3};
    endfunction
    function int exp_states(input logic [2:0] m);
        case (m)
            0: return 4;
            1, 3: return 3;
            2: return 2;
            4: return 1;
            5: return 5;
            default: return 6;
        endcase
    endfunction
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test();
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Call just after a rising edge; ends one idle cycle later
    task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            if (++n > 20) begin
                fail_count++;
                stop_test();
            end
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task wait_frames(input int k);
        int n;
        logic [15:0] f0;
        n = 0;
        f0 = frames;
        while (frames < f0 + k) begin
            if (++n > 20000) begin
                fail_count++;
                stop_test();
            end
            @(posedge clk_i);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        foreach (regs[i]) begin
            wb(0, regs[i], 0);
            check("reset", q, 0);
        end
        wb(1, 16'h9008, 32'hff);
        wb(0, 16'h9008, 0);
        check("unmapped", q, 0);
        sel <= 4'he;
        wb(1, 16'h9004, 32'hc0);
        sel <= 4'hf;
        wb(0, 16'h9004, 0);
        check("sel guard", q, 0);
        for (int m = 0; m < 8; m++) begin
            r = xs();
            wb(1, 16'h9000, {25'h0, m[2:0], 4'h3});
            wb(1, 16'h9004, {24'h0, m[1:0], 6'h0});
            wb(1, 16'h9034, {27'h0, r[4:0]});
            wb(0, 16'h9000, 0);
            check("mode", q, {25'h0, m[2:0], 4'h3});
            wb(0, 16'h9034, 0);
            check("level", q, {27'h0, r[4:0]});
            check("level pin", {27'h0, lvl}, {27'h0, r[4:0]});
            check("decode", {bias, stat, unsup, fifth, sixth, boost, dac, ext},
                exp_dec(m[2:0], m[1:0]));
            if (m < 7) begin
                wait_frames(2);
                check("states", states, exp_states(m[2:0]));
            end else begin
                check("dark", {26'h0, com}, 32'h0);
                check("dark slot", {29'h0, slot}, 32'h0);
            end
        end
        for (int d = 0; d < 4; d++) begin
            wb(1, 16'h9000, 32'h40 | d);
            wait_frames(2);
            check("gap", gap, (512 >> d) * 4);
            check("static slot", {29'h0, slot}, 32'h0);
            check("static com", {26'h0, com}, 32'h1);
        end
        wb(0, 16'h9040, 0);
        check("status", q, 32'h20);
        stop_test();
    end
endmodule // tb_top
